// ---- phy_special_pkg.sv ----
// Constants shared by the special control/status register block.
// Functional notes
// - Register 0x1F at transceiver addresses 1 and 2.
// - Bit5 polarity reversed, bit4 crossover; reset zero.
// - Bit3 set forces link pass.
// - Bit2 zero enables power saving; resets one.
// - Bit1 loops receive pair onto transmit pair.
// - Bits 15..6 read zero; bit0 reserved writable.
// - Port registers 26/42 share the same state.
package phy_special_pkg;

  // Management frame addressing.
  localparam logic [4:0] REG_SPECIAL  = 5'h1F;
  localparam logic [4:0] PHYAD_FIRST  = 5'h01;
  localparam logic [4:0] PHYAD_SECOND = 5'h02;
  localparam logic [1:0] OP_READ      = 2'h2;
  localparam logic [1:0] OP_WRITE     = 2'h1;
  localparam int         PREAMBLE_LEN = 32;
  localparam logic [3:0] HDR_LAST     = 4'hC;
  localparam logic [3:0] DATA_LAST    = 4'hF;

  // Field positions in the 16-bit register.
  localparam int BIT_POLARITY = 5;
  localparam int BIT_MDIX     = 4;
  localparam int BIT_FORCE    = 3;
  localparam int BIT_PWRSAVE  = 2;
  localparam int BIT_LOOP     = 1;
  localparam int BIT_RESV     = 0;

  // Reset values of the writable fields.
  localparam logic RST_FORCE   = 1'b0;
  localparam logic RST_PWRSAVE = 1'b1;
  localparam logic RST_LOOP    = 1'b0;
  localparam logic RST_RESV    = 1'b0;

  // Switch 8-bit port register addresses and bit positions.
  localparam logic [7:0] SW_CTRL_P1   = 8'h1A;
  localparam logic [7:0] SW_CTRL_P2   = 8'h2A;
  localparam logic [7:0] SW_STAT_P1   = 8'h1E;
  localparam logic [7:0] SW_STAT_P2   = 8'h2E;
  localparam logic [7:0] SW_POL_P1    = 8'h1F;
  localparam logic [7:0] SW_POL_P2    = 8'h2F;
  localparam int         SW_BIT_MDIX  = 7;
  localparam int         SW_BIT_POL   = 5;

endpackage

// ---- phy_bank_if.sv ----
// Carrier between the access logic and the per-transceiver state bank.
`timescale 1ns/10ps
interface phy_bank_if;
  logic       mii_wr;
  logic       mii_sel;
  logic [3:0] mii_bits;
  logic       sw_wr;
  logic       sw_sel;
  logic [2:0] sw_bits;
  logic [1:0] force_link;
  logic [1:0] pwrsave_off;
  logic [1:0] remote_loop;
  logic [1:0] resv0;
  logic [1:0] polarity;
  logic [1:0] mdix;

  modport access (output mii_wr, mii_sel, mii_bits, sw_wr, sw_sel, sw_bits,
                  input force_link, pwrsave_off, remote_loop, resv0, polarity, mdix);
  modport bank   (input mii_wr, mii_sel, mii_bits, sw_wr, sw_sel, sw_bits,
                  output force_link, pwrsave_off, remote_loop, resv0, polarity, mdix);
endinterface

// ---- phy_state_bank.sv ----
// Per-transceiver control and status flip-flops shared by both access paths.
`timescale 1ns/10ps
module phy_state_bank
  import phy_special_pkg::*;
(
  // Clock and reset.
  input  wire logic  mclk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  // Live status from the two transceivers.
  input  wire logic [1:0] polarity_in,
  input  wire logic [1:0] mdix_in,
  // Access side.
  phy_bank_if.bank   bus
);

  // Each transceiver has its own copy; management writes win a same-cycle clash.
  for (genvar i = 0; i < 2; i++) begin : g_phy
    wire mii_hit = bus.mii_wr && (bus.mii_sel == 1'(i));
    wire sw_hit  = bus.sw_wr && (bus.sw_sel == 1'(i));

    // Control fields follow whichever path writes them.
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        bus.force_link[i]  <= RST_FORCE;
        bus.pwrsave_off[i] <= RST_PWRSAVE;
        bus.remote_loop[i] <= RST_LOOP;
        bus.resv0[i]       <= RST_RESV;
      end else if (ce) begin
        if (mii_hit) begin
          bus.force_link[i]  <= bus.mii_bits[BIT_FORCE];
          bus.pwrsave_off[i] <= bus.mii_bits[BIT_PWRSAVE];
          bus.remote_loop[i] <= bus.mii_bits[BIT_LOOP];
          bus.resv0[i]       <= bus.mii_bits[BIT_RESV];
        end else if (sw_hit) begin
          bus.force_link[i]  <= bus.sw_bits[2];
          bus.pwrsave_off[i] <= bus.sw_bits[1];
          bus.remote_loop[i] <= bus.sw_bits[0];
        end
      end
    end

    // Status fields are sampled from the transceiver every cycle that ce is high.
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        bus.polarity[i] <= 1'b0;
        bus.mdix[i]     <= 1'b0;
      end else if (ce) begin
        bus.polarity[i] <= polarity_in[i];
        bus.mdix[i]     <= mdix_in[i];
      end
    end
  end

endmodule // phy_state_bank

// ---- phy_special_ctrl_status.sv ----
// Management-frame slave and switch port-register path for the special register.
`timescale 1ns/10ps
module phy_special_ctrl_status
  import phy_special_pkg::*;
#(
  parameter int PREAMBLE_MIN = PREAMBLE_LEN
)(
  // Clock, reset and clock enable.
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  // Management pins, sampled as synchronous inputs.
  input  wire logic       mdc,
  input  wire logic       mdio_in,
  output logic            mdio_out,
  output logic            mdio_oe_n,
  // Switch 8-bit port register access.
  input  wire logic [7:0] sw_addr,
  input  wire logic       sw_wr,
  input  wire logic       sw_rd,
  input  wire logic [7:0] sw_wdata,
  output logic [7:0]      sw_rdata,
  output logic            sw_rvalid,
  // Transceiver status in and controls out.
  input  wire logic [1:0] polarity_in,
  input  wire logic [1:0] mdix_in,
  output logic [1:0]      force_link,
  output logic [1:0]      pwrsave_off,
  output logic [1:0]      remote_loop
);

  // Refuse preamble lengths the saturating counter cannot hold.
  if (PREAMBLE_MIN < 1 || PREAMBLE_MIN > 63) begin : g_bad_preamble
    $error("PREAMBLE_MIN must lie between 1 and 63");
  end

  typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} frame_t;

  phy_bank_if bank_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // State bank instance.

  phy_state_bank u_bank (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .ce          (ce),
    .polarity_in (polarity_in),
    .mdix_in     (mdix_in),
    .bus         (bank_bus.bank)
  );

  // Controls leave the block straight from the bank flip-flops.
  assign force_link  = bank_bus.force_link;
  assign pwrsave_off = bank_bus.pwrsave_off;
  assign remote_loop = bank_bus.remote_loop;

  // Builds the 16-bit register image of one transceiver; high bits stay zero.
  function automatic logic [15:0] special_word(input logic sel);
    logic [15:0] w;
    w = 16'h0000;
    w[BIT_POLARITY] = bank_bus.polarity[sel];
    w[BIT_MDIX]     = bank_bus.mdix[sel];
    w[BIT_FORCE]    = bank_bus.force_link[sel];
    w[BIT_PWRSAVE]  = bank_bus.pwrsave_off[sel];
    w[BIT_LOOP]     = bank_bus.remote_loop[sel];
    w[BIT_RESV]     = bank_bus.resv0[sel];
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Management frame engine.

  logic        mdc_reg;
  frame_t      state_reg;
  logic [5:0]  ones_reg;
  logic [3:0]  cnt_reg;
  logic [12:0] hdr_reg;
  logic [15:0] shift_reg;
  logic        read_reg;
  logic        hit_reg;
  logic        sel_reg;

  // Edge detect, header decode and next header image.
  wire         mdc_rise  = ce && mdc && !mdc_reg;
  wire [12:0]  hdr_next  = {hdr_reg[11:0], mdio_in};
  wire [4:0]   hdr_phy   = hdr_next[9:5];
  wire         hdr_start = hdr_next[12];
  wire         hdr_read  = hdr_next[11:10] == OP_READ;
  wire         hdr_write = hdr_next[11:10] == OP_WRITE;
  wire         phy_ok    = (hdr_phy == PHYAD_FIRST) || (hdr_phy == PHYAD_SECOND);
  wire         hdr_hit   = hdr_start && phy_ok && (hdr_next[4:0] == REG_SPECIAL)
                           && (hdr_read || hdr_write);
  wire         hdr_sel   = hdr_phy == PHYAD_SECOND;
  wire         pre_done  = ones_reg >= 6'(PREAMBLE_MIN);
  wire         data_end  = cnt_reg == DATA_LAST;
  wire [15:0]  wr_word   = {shift_reg[14:0], mdio_in};

  // Write strobe towards the bank at the last data bit of a write frame.
  assign bank_bus.mii_wr   = mdc_rise && state_reg == ST_DATA && data_end
                             && hit_reg && !read_reg;
  assign bank_bus.mii_sel  = sel_reg;
  assign bank_bus.mii_bits = wr_word[3:0];

  // MDC history for edge detection.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mdc_reg <= 1'b0;
    end else if (ce) begin
      mdc_reg <= mdc;
    end
  end

  // Frame sequencer; every step happens on a rising MDC edge.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_PRE;
      ones_reg  <= 6'h00;
      cnt_reg   <= 4'h0;
      hdr_reg   <= 13'h0000;
      shift_reg <= 16'h0000;
      read_reg  <= 1'b0;
      hit_reg   <= 1'b0;
      sel_reg   <= 1'b0;
      mdio_out  <= 1'b1;
      mdio_oe_n <= 1'b1;
    end else if (mdc_rise) begin
      unique case (state_reg)
        ST_PRE: begin
          if (mdio_in) begin
            ones_reg <= (ones_reg == 6'h3F) ? ones_reg : ones_reg + 6'h01;
          end else if (pre_done) begin
            state_reg <= ST_HDR;
            hdr_reg   <= 13'h0000;
            cnt_reg   <= 4'h0;
          end else begin
            ones_reg <= 6'h00;
          end
        end
        ST_HDR: begin
          hdr_reg <= hdr_next;
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == HDR_LAST) begin
            state_reg <= ST_TA;
            cnt_reg   <= 4'h0;
            read_reg  <= hdr_read;
            hit_reg   <= hdr_hit;
            sel_reg   <= hdr_sel;
            shift_reg <= special_word(hdr_sel);
          end
        end
        ST_TA: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'h0) begin
            // Second turnaround bit: drive zero on a matching read.
            if (hit_reg && read_reg) begin
              mdio_oe_n <= 1'b0;
              mdio_out  <= 1'b0;
            end
          end else begin
            state_reg <= ST_DATA;
            cnt_reg   <= 4'h0;
            if (hit_reg && read_reg) begin
              mdio_out  <= shift_reg[15];
              shift_reg <= {shift_reg[14:0], 1'b0};
            end
          end
        end
        ST_DATA: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (hit_reg && read_reg) begin
            mdio_out  <= shift_reg[15];
            shift_reg <= {shift_reg[14:0], 1'b0};
          end else begin
            shift_reg <= wr_word;
          end
          if (data_end) begin
            state_reg <= ST_PRE;
            ones_reg  <= 6'h00;
            mdio_oe_n <= 1'b1;
            mdio_out  <= 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch port register path.

  // Address decode of the six port registers that carry these fields.
  wire sw_ctrl = (sw_addr == SW_CTRL_P1) || (sw_addr == SW_CTRL_P2);
  wire sw_stat = (sw_addr == SW_STAT_P1) || (sw_addr == SW_STAT_P2);
  wire sw_pol  = (sw_addr == SW_POL_P1) || (sw_addr == SW_POL_P2);
  wire sw_port = (sw_addr == SW_CTRL_P2) || (sw_addr == SW_STAT_P2) || (sw_addr == SW_POL_P2);

  assign bank_bus.sw_wr   = ce && sw_wr && sw_ctrl;
  assign bank_bus.sw_sel  = sw_port;
  assign bank_bus.sw_bits = sw_wdata[BIT_FORCE:BIT_LOOP];

  // Read image of the addressed port register; unmapped bits read zero.
  logic [7:0] sw_word;
  always_comb begin
    sw_word = 8'h00;
    if (sw_ctrl) begin
      sw_word[BIT_FORCE]   = bank_bus.force_link[sw_port];
      sw_word[BIT_PWRSAVE] = bank_bus.pwrsave_off[sw_port];
      sw_word[BIT_LOOP]    = bank_bus.remote_loop[sw_port];
    end else if (sw_stat) begin
      sw_word[SW_BIT_MDIX] = bank_bus.mdix[sw_port];
    end else if (sw_pol) begin
      sw_word[SW_BIT_POL]  = bank_bus.polarity[sw_port];
    end
  end

  // Read answer one cycle after the request.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sw_rdata  <= 8'h00;
      sw_rvalid <= 1'b0;
    end else if (ce) begin
      sw_rvalid <= sw_rd;
      sw_rdata  <= sw_rd ? sw_word : 8'h00;
    end
  end

endmodule // phy_special_ctrl_status

// ---- phy_special_monitor.sv ----
// Checker that watches the special control/status block at its ports.
`timescale 1ns/10ps
module phy_special_monitor
  import phy_special_pkg::*;
#(parameter int PREAMBLE_MIN = 32)(
  // Clock, reset and enable.
  input wire logic       mclk, rst_n, ce,
  // Management pins.
  input wire logic       mdc, mdio_in, mdio_out, mdio_oe_n,
  // Switch port access.
  input wire logic [7:0] sw_addr, sw_wdata, sw_rdata,
  input wire logic       sw_wr, sw_rd, sw_rvalid,
  // Transceiver status and controls.
  input wire logic [1:0] polarity_in, mdix_in, force_link, pwrsave_off, remote_loop
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic       mdc_q;
  logic [4:0] rise_cnt;
  // Counts management clock rises while the data pin is driven.
  always_ff @(posedge mclk) begin
    mdc_q <= mdc;
    if (mdio_oe_n) rise_cnt <= 5'h00;
    else if (mdc && !mdc_q) rise_cnt <= rise_cnt + 5'h01;
  end
  sequence s_drive_start; $fell(mdio_oe_n); endsequence
  sequence s_release; $rose(mdio_oe_n); endsequence
  a_rvalid_follows: assert property (sw_rd && ce |=> sw_rvalid)
    else $error("read strobe without valid");
  a_rdata_idle: assert property (!sw_rvalid |-> sw_rdata == 8'h00)
    else $error("read data not zero when idle");
  a_ctrl_wr_one: assert property (ce && sw_wr && sw_addr == SW_CTRL_P1 |=>
    {force_link[0], pwrsave_off[0], remote_loop[0]} == $past(sw_wdata[3:1]))
    else $error("port 1 control write lost");
  a_ctrl_wr_two: assert property (ce && sw_wr && sw_addr == SW_CTRL_P2 |=>
    {force_link[1], pwrsave_off[1], remote_loop[1]} == $past(sw_wdata[3:1]))
    else $error("port 2 control write lost");
  a_ctrl_reset: assert property ($rose(rst_n) |->
    force_link == 2'h0 && pwrsave_off == 2'h3 && remote_loop == 2'h0)
    else $error("controls wrong after reset");
  a_idle_high: assert property (mdio_oe_n |-> mdio_out)
    else $error("data pin not idle high");
  a_out_on_mdc: assert property ($changed(mdio_out) |-> $past(mdc) && !$past(mdc, 2))
    else $error("data pin changed off a clock rise");
  a_ta_zero: assert property (s_drive_start |-> !mdio_out)
    else $error("turnaround bit not zero");
  a_drive_len: assert property (s_release |-> rise_cnt == 5'h11)
    else $error("read drive length wrong");
endmodule // phy_special_monitor

bind phy_special_ctrl_status phy_special_monitor #(.PREAMBLE_MIN(PREAMBLE_MIN)) mon (
  .mclk(mclk), .rst_n(rst_n), .ce(ce), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
  .mdio_oe_n(mdio_oe_n), .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_rdata(sw_rdata),
  .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rvalid(sw_rvalid), .polarity_in(polarity_in),
  .mdix_in(mdix_in), .force_link(force_link), .pwrsave_off(pwrsave_off),
  .remote_loop(remote_loop)
);

// ---- mdio_master.sv ----
// Behavioural management controller that sends clause-22 frames.
`timescale 1ns/10ps
module mdio_master
  import phy_special_pkg::*;
(
  // Clock.
  input wire logic mclk,
  // Management pins.
  input wire logic mdio_out,
  input wire logic mdio_oe_n,
  output logic     mdc,
  output logic     mdio_in
);
  logic drv_en;
  logic drv_val;
  // The shared line has a pull-up, so it reads high when nobody drives it.
  assign mdio_in = !mdio_oe_n ? mdio_out : (drv_en ? drv_val : 1'b1);
  initial begin
    mdc = 1'b0;
    drv_en = 1'b0;
    drv_val = 1'b1;
  end
  // One frame; the clock stands low outside it, reads return turnaround and data.
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, regad,
                       input logic [15:0] wd, output logic [16:0] rd);
    logic [63:0] bits;
    bits = {32'hFFFFFFFF, 2'b01, op, phy, regad, 2'b10, wd};
    rd = 17'h00000;
    for (int i = 0; i < 64; i++) begin
      @(posedge mclk);
      mdc <= 1'b0;
      drv_en <= !(op == OP_READ && i >= 46);
      drv_val <= bits[63-i];
      repeat (2) @(posedge mclk);
      mdc <= 1'b1;
      if (i >= 47) rd = {rd[15:0], mdio_in};
      @(posedge mclk);
    end
    @(posedge mclk);
    mdc <= 1'b0;
    drv_en <= 1'b0;
  endtask
endmodule // mdio_master

// ---- tb.sv ----
// Self-checking bench for the special control/status register block.
`timescale 1ns/10ps
module tb;
  import phy_special_pkg::*;
  logic        mclk, rst_n, ce, mdc, mdio_in, mdio_out, mdio_oe_n;
  logic [7:0]  sw_addr, sw_wdata, sw_rdata;
  logic        sw_wr, sw_rd, sw_rvalid;
  logic [1:0]  polarity_in, mdix_in, force_link, pwrsave_off, remote_loop;
  logic [16:0] rd;
  int          n_mismatch;
  int          checked;

  phy_special_ctrl_status dut (
    .mclk(mclk), .rst_n(rst_n), .ce(ce), .mdc(mdc), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .sw_addr(sw_addr), .sw_wr(sw_wr),
    .sw_rd(sw_rd), .sw_wdata(sw_wdata), .sw_rdata(sw_rdata), .sw_rvalid(sw_rvalid),
    .polarity_in(polarity_in), .mdix_in(mdix_in), .force_link(force_link),
    .pwrsave_off(pwrsave_off), .remote_loop(remote_loop)
  );
  mdio_master m (
    .mclk(mclk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n), .mdc(mdc), .mdio_in(mdio_in)
  );

  ////////////////////////////////////////////////////////////////////////
  // Comparison and closing report.
  task automatic check(input string what, input logic [16:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Access tasks for both paths.
  task automatic mread(input logic [4:0] phy, regad, input logic [16:0] exp);
    m.frame(OP_READ, phy, regad, 16'h0000, rd);
    check("mdio read", rd, exp);
  endtask
  task automatic mwrite(input logic [4:0] phy, input logic [15:0] wd);
    m.frame(OP_WRITE, phy, REG_SPECIAL, wd, rd);
  endtask
  task automatic ctl(input logic [5:0] exp);
    check("controls", 17'({force_link, pwrsave_off, remote_loop}), 17'(exp));
  endtask
  task automatic sw_write(input logic [7:0] a, d);
    @(posedge mclk);
    sw_wr <= 1'b1;
    sw_addr <= a;
    sw_wdata <= d;
    @(posedge mclk);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_rchk(input logic [7:0] a, exp);
    int k;
    @(posedge mclk);
    sw_rd <= 1'b1;
    sw_addr <= a;
    @(posedge mclk);
    sw_rd <= 1'b0;
    for (k = 0; k < 4; k++) begin
      #1;
      if (sw_rvalid === 1'b1) break;
      @(posedge mclk);
    end
    if (k == 4) begin
      n_mismatch++;
      complete_run();
    end
    check("port read", 17'(sw_rdata), 17'(exp));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock at 40 MHz.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Main sequence.
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    sw_addr = 8'h00;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    polarity_in = 2'b00;
    mdix_in = 2'b00;
    n_mismatch = 0;
    checked = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    mread(PHYAD_FIRST, REG_SPECIAL, 17'h00004);
    ctl(6'h0C);
    @(posedge mclk);
    polarity_in <= 2'b01;
    mdix_in <= 2'b10;
    mwrite(PHYAD_FIRST, 16'hFFFE);
    mread(PHYAD_FIRST, REG_SPECIAL, 17'h0002E);
    ctl(6'h1D);
    mread(PHYAD_SECOND, REG_SPECIAL, 17'h00014);
    mread(5'h03, REG_SPECIAL, 17'h1FFFF);
    mread(PHYAD_FIRST, 5'h1E, 17'h1FFFF);
    sw_rchk(SW_CTRL_P1, 8'h0E);
    sw_write(SW_CTRL_P2, 8'hFA);
    sw_write(8'h10, 8'hFF);
    mread(PHYAD_SECOND, REG_SPECIAL, 17'h0001A);
    ctl(6'h37);
    sw_rchk(SW_STAT_P2, 8'h80);
    sw_rchk(SW_POL_P1, 8'h20);
    sw_rchk(8'h10, 8'h00);
    mwrite(PHYAD_FIRST, 16'h0000);
    sw_rchk(SW_CTRL_P1, 8'h00);
    ctl(6'h22);
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    ctl(6'h0C);
    ce <= 1'b0;
    sw_write(SW_CTRL_P1, 8'h0E);
    ce <= 1'b1;
    @(posedge mclk);
    ctl(6'h0C);
    sw_write(SW_CTRL_P1, 8'h08);
    mread(PHYAD_FIRST, REG_SPECIAL, 17'h00028);
    ctl(6'h18);
    sw_rchk(SW_CTRL_P2, 8'h04);
    complete_run();
  end
endmodule // tb
